// ==== gdp_map.svh ====
// register map and timing constants of the general digital io port
// assumes a byte-wide io space decoded by the surrounding cpu core
`ifndef GDP_MAP_SVH
`define GDP_MAP_SVH

// ----------------------------------------
// io locations of one port
// ----------------------------------------
`define GDP_ADDR_W 2
`define GDP_OFS_INPUT_SAMPLE 2'h0
`define GDP_OFS_DIRECTION 2'h1
`define GDP_OFS_OUTPUT_VALUE 2'h2
`define GDP_OFS_SPECIAL_FUNC 2'h3

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define GDP_PUD_BIT 2
`define GDP_RST_DIRECTION 8'h00
`define GDP_RST_OUTPUT_VALUE 8'h00
`define GDP_RST_PUD 1'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define GDP_CLK_PERIOD_NS 100
`define GDP_SW_SYNC_NS 100
`define GDP_SW_SYNC_CYC ((`GDP_SW_SYNC_NS + `GDP_CLK_PERIOD_NS - 1) / `GDP_CLK_PERIOD_NS)

`endif

// ==== gdp_pkg.sv ====
// types shared by the general digital io port
// assumes gdp_map.svh is on the include path
package gdp_pkg;
	typedef logic [7:0] gdp_byte_t;
	// pin configuration, one-hot over the four pin states
	typedef enum logic [3:0] {
		GDP_CFG_TRISTATE = 4'h1,
		GDP_CFG_PULLUP = 4'h2,
		GDP_CFG_DRIVE_LOW = 4'h4,
		GDP_CFG_DRIVE_HIGH = 4'h8
	} gdp_cfg_e;
endpackage

// ==== gdp_sync.sv ====
// input synchroniser of one pin: latch open while clk high, then a flop
// assumes the pin level is already clamped for sleep where needed
module gdp_sync (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pin_level,
	output logic sample_r
);
	logic hold_lat;

	// ----------------------------------------
	// half-cycle latch then rising-edge flop
	// ----------------------------------------
	// [RULE10] transparent latch stage
	// nonblocking, so the flop at the opening edge still reads the held value
	always_latch begin
		if (clk) begin
			hold_lat <= pin_level;
		end
	end

	// [RULE11] sample on rising edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sample_r <= 1'b0;
		end else begin
			sample_r <= hold_lat;
		end
	end
endmodule

// ==== gdp_port.sv ====
// general digital io port: direction, output value, pull-up and sampled input
// assumes the cpu core drives the io strobes on clk and one access per cycle
//
// Overview of operation
// [RULE1] direction bit one makes output, zero input
// [RULE2] pull-up on when input, value one, enabled
// [RULE3] pull-up off when value zero or output
// [RULE4] global disable bit kills every pull-up
// [RULE5] reset tri-states pins without needing clock
// [RULE6] output pin drives its value bit
// [RULE7] software passes intermediate state, tri-state to high
// [RULE8] software passes intermediate state, pull-up to low
// [RULE9] input sample readable in any direction
// [RULE10] latch open on clock high, then flop
// [RULE11] pin change seen after half to 1.5 cycles
// [RULE12] written value readable back after one idle cycle
// [RULE13] single-bit set and clear leave others unchanged
// [RULE14] three locations: value, direction rw; sample ro; the port also decodes the special register as a fourth location
// [RULE15] per-pin logic independent of other pins
// [RULE16] global pull-up disable is special register bit 2
// [RULE17] sleep clamps input low unless interrupt pin
// [RULE18] all control bits reset to zero
`include "gdp_map.svh"
module gdp_port
	import gdp_pkg::*;
#(
	parameter int PIN_W = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [`GDP_ADDR_W-1:0] io_addr,
	input wire logic io_wr,
	input wire logic [7:0] io_wdata,
	input wire logic io_rd,
	input wire logic io_bit_set,
	input wire logic io_bit_clr,
	input wire logic [2:0] io_bit_sel,
	output logic [7:0] io_rdata,
	input wire logic sleep_clamp,
	input wire logic [PIN_W-1:0] ext_int_en,
	input wire logic [PIN_W-1:0] pad_in,
	output logic [PIN_W-1:0] pad_out,
	output logic [PIN_W-1:0] pad_oe,
	output logic [PIN_W-1:0] pad_pullup
);
	// per-pin checks index bit 1, so a single pin is refused too
	if (PIN_W < 2 || PIN_W > 8) begin : g_bad_width
		$error("PIN_W must be 2 to 8");
	end

	logic [PIN_W-1:0] dir_r, dir_nxt;
	logic [PIN_W-1:0] val_r, val_nxt;
	logic pud_r, pud_nxt;
	logic [PIN_W-1:0] pull_r, drive_r, sample_r;
	logic [7:0] rdata_r;
	logic [7:0] bit_mask;

	// ----------------------------------------
	// register writes and bit operations
	// ----------------------------------------
	// a bit index beyond PIN_W falls off the slice and changes nothing
	assign bit_mask = 8'h01 << io_bit_sel;

	always_comb begin
		dir_nxt = dir_r;
		val_nxt = val_r;
		pud_nxt = pud_r;
		// [RULE14] value, direction and special function are writable; sample is not
		if (io_wr) begin
			case (io_addr)
				`GDP_OFS_DIRECTION: dir_nxt = io_wdata[PIN_W-1:0];
				`GDP_OFS_OUTPUT_VALUE: val_nxt = io_wdata[PIN_W-1:0];
				`GDP_OFS_SPECIAL_FUNC: pud_nxt = io_wdata[`GDP_PUD_BIT];
				default: ;
			endcase
		// [RULE13] single bit set or clear
		end else if (io_bit_set || io_bit_clr) begin
			case (io_addr)
				`GDP_OFS_DIRECTION: dir_nxt = io_bit_set ? (dir_r | bit_mask[PIN_W-1:0])
					: (dir_r & ~bit_mask[PIN_W-1:0]);
				`GDP_OFS_OUTPUT_VALUE: val_nxt = io_bit_set ? (val_r | bit_mask[PIN_W-1:0])
					: (val_r & ~bit_mask[PIN_W-1:0]);
				`GDP_OFS_SPECIAL_FUNC: begin
					// [RULE16] pull-up disable at bit 2
					if (io_bit_sel == 3'(`GDP_PUD_BIT)) begin
						pud_nxt = io_bit_set;
					end
				end
				default: ;
			endcase
		end
	end

	// [RULE18] control bits reset to zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dir_r <= `GDP_RST_DIRECTION;
			val_r <= `GDP_RST_OUTPUT_VALUE;
			pud_r <= `GDP_RST_PUD;
		end else begin
			dir_r <= dir_nxt;
			val_r <= val_nxt;
			pud_r <= pud_nxt;
		end
	end

	// ----------------------------------------
	// per-pin driver, pull-up and synchroniser
	// ----------------------------------------
	// [RULE15] each pin stands alone
	for (genvar i = 0; i < PIN_W; i++) begin : g_pin
		logic clamped;
		// [RULE17] sleep clamp unless interrupt pin
		assign clamped = pad_in[i] & ~(sleep_clamp & ~ext_int_en[i]);

		// [RULE2] [RULE3] [RULE4] pull-up decode
		// decoded from next values so the pads never lag the registers
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				pull_r[i] <= 1'b0;
				drive_r[i] <= 1'b0;
			end else begin
				pull_r[i] <= ~dir_nxt[i] & val_nxt[i] & ~pud_nxt;
				// [RULE1] direction selects driver
				drive_r[i] <= dir_nxt[i];
			end
		end

		// [RULE12] own drive readable after one idle cycle
		gdp_sync u_sync (
			.clk(clk),
			.sys_rst(sys_rst),
			.pin_level(clamped),
			.sample_r(sample_r[i])
		);
	end

	// [RULE6] output value onto the pad
	assign pad_out = val_r;
	// [RULE5] reset gates drivers off at once, clock or not
	// trade-off: these gates on pad_oe and pad_pullup are the pin paths not straight off a flop
	assign pad_oe = drive_r & {PIN_W{~sys_rst}};
	assign pad_pullup = pull_r & {PIN_W{~sys_rst}};

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// bits above PIN_W read zero through the size casts
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
		end else if (io_rd) begin
			case (io_addr)
				// [RULE9] sample readable in any direction
				`GDP_OFS_INPUT_SAMPLE: rdata_r <= 8'(sample_r);
				`GDP_OFS_DIRECTION: rdata_r <= 8'(dir_r);
				`GDP_OFS_OUTPUT_VALUE: rdata_r <= 8'(val_r);
				`GDP_OFS_SPECIAL_FUNC: rdata_r <= 8'(pud_r) << `GDP_PUD_BIT;
				default: rdata_r <= 8'h00;
			endcase
		end
	end
	assign io_rdata = rdata_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// bit 0 stands for every pin, since the pin logic is one generate loop
	sequence s_dir_write0;
		io_wr && io_addr == `GDP_OFS_DIRECTION && io_wdata[0];
	endsequence

	sequence s_val_clr0;
		io_bit_clr && !io_bit_set && !io_wr
			&& io_addr == `GDP_OFS_OUTPUT_VALUE && io_bit_sel == 3'h0;
	endsequence

	sequence s_ro_write;
		io_wr && io_addr == `GDP_OFS_INPUT_SAMPLE;
	endsequence

	AST_DIR_OUT: assert property (s_dir_write0 |=> pad_oe[0]) // [RULE1]
		else $error("direction write did not enable driver");
	AST_PULLUP_ON: assert property (!dir_r[0] && val_r[0] && !pud_r |-> pad_pullup[0]) // [RULE2]
		else $error("pull-up missing for input with value one");
	AST_PULLUP_OFF: assert property (!val_r[0] || dir_r[0] |-> !pad_pullup[0]) // [RULE3]
		else $error("pull-up on while value zero or output");
	AST_PUD_ALL: assert property (pud_r |-> pad_pullup == '0) // [RULE4]
		else $error("pull-up on while globally disabled");
	AST_RST_TRI: assert property (@(posedge clk) $fell(sys_rst) |-> pad_oe == '0) // [RULE5]
		else $error("pins driven right after reset");
	AST_RST_REGS: assert property (@(posedge clk) $fell(sys_rst) // [RULE18]
		|-> dir_r == '0 && val_r == '0 && !pud_r)
		else $error("control bits not zero after reset");
	AST_DRIVE_VAL: assert property (io_wr && io_addr == `GDP_OFS_OUTPUT_VALUE // [RULE6]
		|=> pad_out == $past(io_wdata[PIN_W-1:0]))
		else $error("driven level differs from written value");
	AST_SAMPLE_RD: assert property (io_rd && io_addr == `GDP_OFS_INPUT_SAMPLE // [RULE9]
		|=> io_rdata == 8'($past(sample_r)))
		else $error("read of input sample wrong");
	// two quiet cycles cover the latest arrival the latch can see
	AST_SYNC_DELAY: assert property ( // [RULE11]
		(!sys_rst && !sleep_clamp && $stable(pad_in[0]))[*2]
		|-> sample_r[0] == pad_in[0])
		else $error("stable pin not sampled in time");
	AST_BIT_SET: assert property ( // [RULE13]
		io_bit_set && !io_wr && io_addr == `GDP_OFS_OUTPUT_VALUE && io_bit_sel == 3'h0
		|=> val_r[PIN_W-1:1] == $past(val_r[PIN_W-1:1]) && val_r[0])
		else $error("bit set disturbed other pins");
	AST_BIT_CLR: assert property (s_val_clr0 // [RULE13]
		|=> val_r[PIN_W-1:1] == $past(val_r[PIN_W-1:1]) && !val_r[0])
		else $error("bit clear disturbed other pins");
	AST_RO_WRITE: assert property (s_ro_write // [RULE14]
		|=> dir_r == $past(dir_r) && val_r == $past(val_r) && pud_r == $past(pud_r))
		else $error("write to the sample location changed a register");
	// a clamp seen at an edge was already in the latch before that edge
	AST_CLAMP: assert property (sleep_clamp // [RULE17]
		|=> (sample_r & ~$past(ext_int_en)) == '0)
		else $error("clamped pin sampled high");
endmodule

// ==== gdp_board.sv ====
// board model: resolves each pad from port driver, outside source and pull-up
// assumes the bench never drives a pad the port is driving
module gdp_board #(
	parameter int PIN_W = 8
) (
	input wire logic clk,
	input wire logic [PIN_W-1:0] pad_out,
	input wire logic [PIN_W-1:0] pad_oe,
	input wire logic [PIN_W-1:0] pad_pullup,
	input wire logic [PIN_W-1:0] ext_en,
	input wire logic [PIN_W-1:0] ext_val,
	output logic [PIN_W-1:0] pad_level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [PIN_W-1:0] flt_r = '0;
	// an undriven line flips each cycle so it never passes for a real level
	always_ff @(posedge clk) flt_r <= ~pad_level;
	always_comb begin
		for (int i = 0; i < PIN_W; i++) begin
			if (pad_oe[i])
				pad_level[i] = pad_out[i];
			else if (ext_en[i])
				pad_level[i] = ext_val[i];
			else if (pad_pullup[i])
				pad_level[i] = 1'h1;
			else
				pad_level[i] = flt_r[i];
		end
	end
endmodule

// ==== gdp_port_tb.sv ====
// bench of the general digital io port with the board model on its pads
// assumes gdp_map.svh on the include path
`include "gdp_map.svh"
module gdp_port_tb
	import gdp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] WR = 4'h8, RD = 4'h4, ST = 4'h2, CL = 4'h1;
	logic clk = 1'h0, sys_rst = 1'h1, io_wr = 1'h0, io_rd = 1'h0;
	logic io_bit_set = 1'h0, io_bit_clr = 1'h0, sleep_clamp = 1'h0;
	logic [1:0] io_addr = 2'h0;
	logic [2:0] io_bit_sel = 3'h0;
	gdp_byte_t io_wdata = 8'h00, ext_int_en = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
	wire gdp_byte_t io_rdata, pad_level, pad_out, pad_oe, pad_pullup;
	int err_total = 0;
	int checks = 0;

	always #50 clk = ~clk;

	gdp_port #(.PIN_W(8)) u_dut (.clk(clk), .sys_rst(sys_rst), .io_addr(io_addr),
		.io_wr(io_wr), .io_wdata(io_wdata), .io_rd(io_rd), .io_bit_set(io_bit_set),
		.io_bit_clr(io_bit_clr), .io_bit_sel(io_bit_sel), .io_rdata(io_rdata),
		.sleep_clamp(sleep_clamp), .ext_int_en(ext_int_en), .pad_in(pad_level),
		.pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup));
	gdp_board #(.PIN_W(8)) u_board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad_level(pad_level));

	// ----------------------------------------
	// access and compare tasks
	// ----------------------------------------
	task automatic chk(input string what, input gdp_byte_t exp, input gdp_byte_t got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// strobes held one cycle, so every call leaves one idle cycle behind
	task automatic acc(input logic [1:0] a, input logic [3:0] op, input gdp_byte_t d);
		@(posedge clk);
		{io_wr, io_rd, io_bit_set, io_bit_clr} <= op;
		io_addr <= a;
		io_wdata <= d;
		io_bit_sel <= d[2:0];
		@(posedge clk);
		{io_wr, io_rd, io_bit_set, io_bit_clr} <= 4'h0;
		#1;
	endtask

	task automatic rd(input logic [1:0] a, input gdp_byte_t exp, input string what);
		acc(a, RD, 8'h00);
		chk(what, exp, io_rdata);
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		#20000;
		err_total++;
		conclude;
	end

	initial begin
		repeat (5) @(posedge clk);
		chk("oe in reset", 8'h00, pad_oe);
		sys_rst <= 1'h0;
		ext_en <= 8'h30;
		ext_val <= 8'h10;
		rd(`GDP_OFS_DIRECTION, 8'h00, "dir reset");
		rd(`GDP_OFS_SPECIAL_FUNC, 8'h00, "pud reset");
		$display("test reset done");
		acc(`GDP_OFS_OUTPUT_VALUE, WR, 8'hC3);
		acc(`GDP_OFS_DIRECTION, WR, 8'h0F);
		chk("oe", 8'h0F, pad_oe);
		chk("out", 8'h03, pad_out & pad_oe);
		chk("pullup", 8'hC0, pad_pullup);
		rd(`GDP_OFS_INPUT_SAMPLE, 8'hD3, "sample");
		@(posedge clk);
		sleep_clamp <= 1'h1;
		ext_int_en <= 8'h01;
		rd(`GDP_OFS_INPUT_SAMPLE, 8'h01, "clamped sample");
		@(posedge clk);
		sleep_clamp <= 1'h0;
		ext_val <= 8'h30;
		rd(`GDP_OFS_INPUT_SAMPLE, 8'hF3, "pin change");
		$display("test pins done");
		acc(`GDP_OFS_DIRECTION, ST, 8'h07);
		acc(`GDP_OFS_OUTPUT_VALUE, CL, 8'h00);
		rd(`GDP_OFS_DIRECTION, 8'h8F, "dir bit set");
		rd(`GDP_OFS_OUTPUT_VALUE, 8'hC2, "val bit clr");
		chk("pullup on output", 8'h40, pad_pullup);
		// pin 6 leaves its pull-up for output low by way of output high
		acc(`GDP_OFS_DIRECTION, ST, 8'h06);
		chk("pullup off as output", 8'h00, pad_pullup);
		acc(`GDP_OFS_OUTPUT_VALUE, CL, 8'h06);
		chk("out low", 8'h82, pad_out & pad_oe);
		rd(`GDP_OFS_INPUT_SAMPLE, 8'hB2, "sample of outputs");
		acc(`GDP_OFS_OUTPUT_VALUE, ST, 8'h00);
		acc(`GDP_OFS_INPUT_SAMPLE, WR, 8'hFF);
		rd(`GDP_OFS_OUTPUT_VALUE, 8'h83, "val after ro write");
		rd(`GDP_OFS_DIRECTION, 8'hCF, "dir after ro write");
		acc(`GDP_OFS_OUTPUT_VALUE, ST, 8'h04);
		chk("pullup on input", 8'h10, pad_pullup);
		acc(`GDP_OFS_SPECIAL_FUNC, WR, 8'hFF);
		chk("pullup disabled", 8'h00, pad_pullup);
		rd(`GDP_OFS_SPECIAL_FUNC, 8'h04, "pud bit");
		acc(`GDP_OFS_SPECIAL_FUNC, CL, 8'h02);
		chk("pullup restored", 8'h10, pad_pullup);
		$display("test registers done");
		@(posedge clk);
		sys_rst <= 1'h1;
		#1;
		chk("oe at reset", 8'h00, pad_oe);
		chk("pullup at reset", 8'h00, pad_pullup);
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		rd(`GDP_OFS_DIRECTION, 8'h00, "dir after reset");
		rd(`GDP_OFS_OUTPUT_VALUE, 8'h00, "val after reset");
		$display("test second reset done");
		conclude;
	end
endmodule
